//--- common/tam_pkg.sv
package tam_pkg;
  // trunk variants
  typedef enum logic [1:0] {
    TAM_VAR_T1,
    TAM_VAR_E1_CHANNEL_SIGNALLING_VARIANT,
    TAM_VAR_PRI
  } tam_variant_e;

  // card maintenance states
  typedef enum logic [1:0] {
    TAM_ACTIVE,
    TAM_MAINT,
    TAM_OOS,
    TAM_DIAG
  } tam_state_e;

  // outward pattern selection
  typedef enum logic [2:0] {
    TAM_TX_NONE,
    TAM_TX_YELLOW,
    TAM_TX_RAI,
    TAM_TX_ONES,
    TAM_TX_BLOCKED
  } tam_tx_e;

  // front-panel leds
  typedef struct packed {
    logic red;
    logic yellow;
    logic green;
  } tam_led_s;

  // apb register byte offsets
  localparam logic [7:0] TAM_CTRL_OFS = 8'h00;
  localparam logic [7:0] TAM_STAT_OFS = 8'h04;
  localparam logic [7:0] TAM_SLIP_THR_OFS = 8'h08;
  localparam logic [7:0] TAM_OOF_THR_OFS = 8'h0C;
  localparam logic [7:0] TAM_LOF_THR_OFS = 8'h10;
  localparam logic [7:0] TAM_CNT_OFS = 8'h14;
  localparam logic [7:0] TAM_T309_OFS = 8'h18;

  // ctrl field positions
  localparam int TAM_C_VAR = 0;      // [1:0]
  localparam int TAM_C_MANFLAG = 2;
  localparam int TAM_C_CMD_MAINT = 3;
  localparam int TAM_C_CMD_OOS = 4;
  localparam int TAM_C_CMD_DIAG = 5;
  localparam int TAM_C_CMD_ACTIVE = 6;
  localparam int TAM_C_CLR_THR = 7;  // write 1 pulse
  localparam int TAM_C_REM_LOOP = 8;
  localparam int TAM_C_DOWNLOAD = 9;
  localparam int TAM_C_SELFTEST_FAIL = 10;
  localparam int TAM_C_COMM_ERR = 11;

  // reset values
  localparam logic [7:0] TAM_SLIP_THR_RST = 8'hFF;
  localparam logic [7:0] TAM_OOF_THR_RST = 8'h04;
  localparam logic [7:0] TAM_LOF_THR_RST = 8'h04;

  // timing
  localparam longint TAM_CLK_HZ = 250_000_000;
  localparam longint TAM_T309_S = 90;
  localparam longint TAM_T309_CYC = TAM_T309_S * TAM_CLK_HZ;
  localparam longint TAM_OOF_MS10 = 25;     // 2.5 s in tenths
  localparam longint TAM_OOF_CYC = TAM_OOF_MS10 * TAM_CLK_HZ / 10;
  localparam longint TAM_LOF_MIN_MS = 12;
  localparam longint TAM_LOF_CYC = TAM_LOF_MIN_MS * TAM_CLK_HZ / 1000;
  localparam longint TAM_WIN_H = 24;
  localparam longint TAM_WIN_CYC = TAM_WIN_H * 3600 * TAM_CLK_HZ;
  localparam int TAM_RB_FRAMES = 6;   // robbed-bit spacing
  localparam int TAM_SF_FRAMES = 12;  // superframe length
  localparam int TAM_T1_CHANS = 24;
endpackage

//--- hw/tam_trunk_alarm.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// - major alarm on carrier loss, self-test fail, oos, supervision timeout.
// - minor alarm on remote alarm, slip threshold, oof, lof and their limits.
// - exactly one state at a time: active, maintenance, oos, diagnostic.
// - active state sends no alarm pattern and keeps leds dark.
// - any inbound alarm forces maintenance; alarm patterns may then go out.
// - maintenance keeps calls, refuses new ones, idles channels to near-end.
// - maintenance also during firmware download or on manual command.
// - out of service sends blocked or unframed ones; yellow and green lit.
// - diagnostic: no calls, local loopback, blocked/ones out, remote loop opt.
// - remote alarm detected by t1 bit2 zeros, e1 rai, or 8 ones 8 zeros.
// - remote alarm: yellow, minor, maintenance, auto-return when clear.
// - e1 distant multiframe alarm bit set gives yellow, minor, maintenance.
// - t1 robbed bits replace lsb every sixth frame, a then b, 12 frames.
// - missing t1 signalling framing gives red, minor, maintenance; oof wins.
// - slips counted; threshold (255) within 24 hours raises minor alarm.
// - manual flag: slip threshold locks maintenance until oos then active.
// - carrier loss: maintenance, yellow outward (rai on e1), busy trunks, red, major.
// - framing bit gone over 2.5 s: oof counted, red, minor, maint, yellow (rai on e1).
// - oof threshold (4) latches alarm; manual flag holds maintenance.
// - no alignment within 12 ms reports lof: count, red, minor, maint, rai.
// - four lof reports latch alarm; manual flag holds maintenance.
// - threshold alarms stay latched until explicit manual clear.
module tam_trunk_alarm
  import tam_pkg::*;
#(
  parameter longint T309_CYC = tam_pkg::TAM_T309_CYC,
  parameter longint OOF_CYC = tam_pkg::TAM_OOF_CYC,
  parameter longint LOF_CYC = tam_pkg::TAM_LOF_CYC,
  parameter longint WIN_CYC = tam_pkg::TAM_WIN_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // line-side indications (asynchronous)
  input wire logic carrier_present,
  input wire logic rx_bit2_zero_all,
  input wire logic rx_rai,
  input wire logic rx_dma_bit,
  input wire logic rx_sig_framing_ok,
  input wire logic rx_term_framing_ok,
  input wire logic rx_frame_aligned,
  input wire logic rx_bit,
  input wire logic rx_bit_stb,
  input wire logic slip_evt,
  input wire logic dchan_alive,
  // channel idle per channel
  input wire logic [23:0] chan_idle,
  // outputs
  output tam_pkg::tam_state_e card_state,
  output tam_pkg::tam_tx_e tx_pattern,
  output tam_pkg::tam_led_s leds,
  output logic major_alarm,
  output logic minor_alarm,
  output logic accept_new_calls,
  output logic call_proc_en,
  output logic busy_trunks,
  output logic local_loop,
  output logic remote_loop,
  output logic [23:0] chan_near_maint
);
  import tam_pkg::*;

  // two-flop synchronisers for asynchronous line inputs
  localparam int NS = 11;
  // idle line levels, so leaving reset raises no false alarm
  localparam logic [NS-1:0] S_IDLE = 11'h471;
  logic [NS-1:0] s1_reg, s2_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= S_IDLE;
      s2_reg <= S_IDLE;
    end else begin
      s1_reg <= {carrier_present, rx_bit2_zero_all, rx_rai, rx_dma_bit,
                 rx_sig_framing_ok, rx_term_framing_ok, rx_frame_aligned,
                 rx_bit, rx_bit_stb, slip_evt, dchan_alive};
      s2_reg <= s1_reg;
    end
  end
  wire carrier = s2_reg[10];
  wire b2z = s2_reg[9];
  wire rai_in = s2_reg[8];
  wire dma_in = s2_reg[7];
  wire sfr_ok = s2_reg[6];
  wire tfr_ok = s2_reg[5];
  wire aligned = s2_reg[4];
  wire rbit = s2_reg[3];
  wire rstb = s2_reg[2];
  wire slip = s2_reg[1];
  wire dalive = s2_reg[0];

  // edge history for strobes
  logic stb_d_reg, slip_d_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_d_reg <= 1'b0;
      slip_d_reg <= 1'b0;
    end else begin
      stb_d_reg <= rstb;
      slip_d_reg <= slip;
    end
  end
  wire bit_evt = rstb & ~stb_d_reg;
  wire slip_rise = slip & ~slip_d_reg;

  // control registers
  logic [11:0] ctrl_reg;
  logic [7:0] slip_thr_reg, oof_thr_reg, lof_thr_reg;
  wire wr = psel & penable & pwrite;
  wire wr_ctrl = wr & (paddr == TAM_CTRL_OFS);
  tam_variant_e variant;
  assign variant = tam_variant_e'(ctrl_reg[TAM_C_VAR +: 2]);
  wire manflag = ctrl_reg[TAM_C_MANFLAG];
  wire cmd_maint = wr_ctrl & pwdata[TAM_C_CMD_MAINT];
  wire cmd_oos = wr_ctrl & pwdata[TAM_C_CMD_OOS];
  wire cmd_diag = wr_ctrl & pwdata[TAM_C_CMD_DIAG];
  wire cmd_act = wr_ctrl & pwdata[TAM_C_CMD_ACTIVE];
  wire cmd_clr = wr_ctrl & pwdata[TAM_C_CLR_THR];

  // apb writes; command bits self-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0;
      slip_thr_reg <= TAM_SLIP_THR_RST;
      oof_thr_reg <= TAM_OOF_THR_RST;
      lof_thr_reg <= TAM_LOF_THR_RST;
    end else if (wr) begin
      unique case (paddr)
        TAM_CTRL_OFS: ctrl_reg <= {pwdata[11:8], 5'b0_0000, pwdata[2:0]};
        TAM_SLIP_THR_OFS: slip_thr_reg <= pwdata[7:0];
        TAM_OOF_THR_OFS: oof_thr_reg <= pwdata[7:0];
        TAM_LOF_THR_OFS: lof_thr_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // remote alarm per variant
  logic [3:0] ones_reg, zeros_reg;
  logic pri_yel_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ones_reg <= '0;
      zeros_reg <= '0;
      pri_yel_reg <= 1'b0;
    end else if (bit_evt) begin
      if (rbit) begin
        // a one after any zero run restarts the ones count; the alarm stays only after a full run
        if (zeros_reg != 4'd0) begin
          pri_yel_reg <= (zeros_reg == 4'd8) & pri_yel_reg;
          ones_reg <= 4'd1;
        end else if (ones_reg != 4'd8) begin
          ones_reg <= ones_reg + 4'd1;
        end
        zeros_reg <= '0;
      end else if (ones_reg == 4'd8) begin
        zeros_reg <= zeros_reg + 4'd1;
        if (zeros_reg == 4'd7) begin
          pri_yel_reg <= 1'b1;
          ones_reg <= '0;
        end
      end else begin
        ones_reg <= '0;
        zeros_reg <= '0;
        pri_yel_reg <= 1'b0;
      end
    end
  end
  logic remote_alm;
  always_comb begin
    unique case (variant)
      TAM_VAR_T1: remote_alm = b2z;
      TAM_VAR_E1_CHANNEL_SIGNALLING_VARIANT: remote_alm = rai_in;
      TAM_VAR_PRI: remote_alm = pri_yel_reg;
      default: remote_alm = 1'b0;
    endcase
  end
  wire dma_alm = (variant == TAM_VAR_E1_CHANNEL_SIGNALLING_VARIANT) & dma_in;

  // duration timers: oof, lof, t309, window
  logic [39:0] oof_t_reg, lof_t_reg, t309_reg;
  logic [47:0] win_reg;
  logic oof_reg, lof_reg, t309_exp_reg;
  wire win_end = (win_reg == 48'(WIN_CYC - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oof_t_reg <= '0;
      lof_t_reg <= '0;
      t309_reg <= '0;
      win_reg <= '0;
      oof_reg <= 1'b0;
      lof_reg <= 1'b0;
      t309_exp_reg <= 1'b0;
    end else begin
      // framing bit must be gone longer than 2.5 s
      oof_t_reg <= tfr_ok ? '0 : (oof_reg ? oof_t_reg : oof_t_reg + 40'd1);
      oof_reg <= ~tfr_ok & (oof_reg | (oof_t_reg == 40'(OOF_CYC)));
      lof_t_reg <= aligned ? '0 : (lof_reg ? lof_t_reg : lof_t_reg + 40'd1);
      lof_reg <= ~aligned & (lof_reg | (lof_t_reg == 40'(LOF_CYC - 1)));
      // supervision only applies to primary-rate
      if (dalive || variant != TAM_VAR_PRI) begin
        t309_reg <= '0;
        t309_exp_reg <= 1'b0;
      end else if (t309_reg == 40'(T309_CYC - 1)) begin
        t309_exp_reg <= 1'b1;
      end else begin
        t309_reg <= t309_reg + 40'd1;
      end
      win_reg <= win_end ? '0 : win_reg + 48'd1;
    end
  end
  logic oof_d_reg, lof_d_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oof_d_reg <= 1'b0;
      lof_d_reg <= 1'b0;
    end else begin
      oof_d_reg <= oof_reg;
      lof_d_reg <= lof_reg;
    end
  end
  wire oof_rpt = oof_reg & ~oof_d_reg;
  wire lof_rpt = lof_reg & ~lof_d_reg;
  wire sig_alm = ~sfr_ok & ~oof_reg & (variant == TAM_VAR_T1);

  // report counters; window end clears, event in same cycle still counts
  logic [7:0] slip_cnt_reg, oof_cnt_reg, lof_cnt_reg;
  logic slip_thr_alm_reg, oof_thr_alm_reg, lof_thr_alm_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slip_cnt_reg <= '0;
      oof_cnt_reg <= '0;
      lof_cnt_reg <= '0;
    end else begin
      slip_cnt_reg <= (win_end ? 8'd0 : slip_cnt_reg)
                      + {7'd0, slip_rise & (slip_cnt_reg != 8'hFF)};
      oof_cnt_reg <= (win_end ? 8'd0 : oof_cnt_reg)
                     + {7'd0, oof_rpt & (oof_cnt_reg != 8'hFF)};
      lof_cnt_reg <= (win_end ? 8'd0 : lof_cnt_reg)
                     + {7'd0, lof_rpt & (lof_cnt_reg != 8'hFF)};
    end
  end
  wire slip_hit = slip_rise & (slip_cnt_reg + 8'd1 >= slip_thr_reg);
  wire oof_hit = oof_rpt & (oof_cnt_reg + 8'd1 >= oof_thr_reg);
  wire lof_hit = lof_rpt & (lof_cnt_reg + 8'd1 >= lof_thr_reg);

  // latched threshold alarms; a new hit wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slip_thr_alm_reg <= 1'b0;
      oof_thr_alm_reg <= 1'b0;
      lof_thr_alm_reg <= 1'b0;
    end else begin
      slip_thr_alm_reg <= slip_hit | (slip_thr_alm_reg & ~cmd_clr);
      oof_thr_alm_reg <= oof_hit | (oof_thr_alm_reg & ~cmd_clr);
      lof_thr_alm_reg <= lof_hit | (lof_thr_alm_reg & ~cmd_clr);
    end
  end

  // manual-recovery locks on maintenance
  logic slip_lock_reg, fr_lock_reg;
  wire carrier_loss = ~carrier;
  wire inbound_alm = remote_alm | dma_alm | sig_alm | oof_reg | lof_reg
                     | carrier_loss;
  tam_state_e state_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slip_lock_reg <= 1'b0;
      fr_lock_reg <= 1'b0;
    end else begin
      // only out of service releases a slip lock
      if (slip_hit & manflag) slip_lock_reg <= 1'b1;
      else if (state_reg == TAM_OOS) slip_lock_reg <= 1'b0;
      if ((oof_hit | lof_hit) & manflag) fr_lock_reg <= 1'b1;
      else if (cmd_act | (state_reg == TAM_OOS)) fr_lock_reg <= 1'b0;
    end
  end

  // card state machine; one state at a time by construction
  wire want_maint = inbound_alm | slip_lock_reg | fr_lock_reg
                    | ctrl_reg[TAM_C_DOWNLOAD];
  logic man_maint_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      man_maint_reg <= 1'b0;
    end else if (cmd_maint) begin
      man_maint_reg <= 1'b1;
    end else if (cmd_act | cmd_oos | cmd_diag) begin
      man_maint_reg <= 1'b0;
    end
  end
  wire oos_force = ctrl_reg[TAM_C_COMM_ERR];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= TAM_ACTIVE;
    end else begin
      unique case (state_reg)
        TAM_ACTIVE, TAM_MAINT: begin
          if (cmd_oos | oos_force) state_reg <= TAM_OOS;
          else if (cmd_diag) state_reg <= TAM_DIAG;
          else if (want_maint | man_maint_reg | cmd_maint)
            state_reg <= TAM_MAINT;
          else state_reg <= TAM_ACTIVE; // auto-return
        end
        TAM_OOS: if (cmd_act & ~oos_force) state_reg <= TAM_MAINT;
        TAM_DIAG: begin
          if (cmd_act) state_reg <= TAM_MAINT;
          else if (cmd_oos) state_reg <= TAM_OOS;
        end
      endcase
    end
  end

  // outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_state <= TAM_ACTIVE;
      tx_pattern <= TAM_TX_NONE;
      leds <= '0;
      major_alarm <= 1'b0;
      minor_alarm <= 1'b0;
      accept_new_calls <= 1'b0;
      call_proc_en <= 1'b0;
      busy_trunks <= 1'b0;
      local_loop <= 1'b0;
      remote_loop <= 1'b0;
      chan_near_maint <= '0;
    end else begin
      card_state <= state_reg;
      major_alarm <= carrier_loss | ctrl_reg[TAM_C_SELFTEST_FAIL]
                     | (state_reg == TAM_OOS) | t309_exp_reg;
      minor_alarm <= remote_alm | dma_alm | sig_alm | oof_reg | lof_reg
                     | slip_thr_alm_reg | oof_thr_alm_reg
                     | lof_thr_alm_reg;
      busy_trunks <= carrier_loss;
      local_loop <= (state_reg == TAM_DIAG);
      remote_loop <= (state_reg == TAM_DIAG) & ctrl_reg[TAM_C_REM_LOOP];
      unique case (state_reg)
        TAM_ACTIVE: begin
          tx_pattern <= TAM_TX_NONE;
          leds <= '0;
          accept_new_calls <= 1'b1;
          call_proc_en <= 1'b1;
          chan_near_maint <= '0;
        end
        TAM_MAINT: begin
          // outward yellow (rai on e1) on carrier loss or oof, rai on lof
          if (carrier_loss | oof_reg)
            tx_pattern <= (variant == TAM_VAR_E1_CHANNEL_SIGNALLING_VARIANT) ? TAM_TX_RAI
                                                      : TAM_TX_YELLOW;
          else if (lof_reg) tx_pattern <= TAM_TX_RAI;
          else tx_pattern <= TAM_TX_NONE;
          leds.red <= carrier_loss | sig_alm | oof_reg | lof_reg;
          leds.yellow <= remote_alm | dma_alm;
          leds.green <= 1'b0;
          accept_new_calls <= 1'b0;
          call_proc_en <= 1'b1;
          chan_near_maint <= chan_near_maint | chan_idle;
        end
        TAM_OOS, TAM_DIAG: begin
          tx_pattern <= (variant == TAM_VAR_E1_CHANNEL_SIGNALLING_VARIANT) ? TAM_TX_BLOCKED
                                                    : TAM_TX_ONES;
          leds.red <= 1'b0;
          leds.yellow <= (state_reg == TAM_OOS);
          leds.green <= (state_reg == TAM_OOS);
          accept_new_calls <= 1'b0;
          call_proc_en <= 1'b0;
          chan_near_maint <= '0;
        end
      endcase
    end
  end

  // apb: zero wait states, no errors; unmapped reads zero
  logic [31:0] rd;
  always_comb begin
    rd = '0;
    unique case (paddr)
      TAM_CTRL_OFS: rd = {20'd0, ctrl_reg};
      TAM_STAT_OFS: rd = {20'd0, lof_thr_alm_reg, oof_thr_alm_reg,
                          slip_thr_alm_reg, t309_exp_reg, lof_reg, oof_reg,
                          sig_alm, dma_alm, remote_alm, carrier_loss,
                          state_reg};
      TAM_SLIP_THR_OFS: rd = {24'd0, slip_thr_reg};
      TAM_OOF_THR_OFS: rd = {24'd0, oof_thr_reg};
      TAM_LOF_THR_OFS: rd = {24'd0, lof_thr_reg};
      TAM_CNT_OFS: rd = {8'd0, lof_cnt_reg, oof_cnt_reg, slip_cnt_reg};
      default: rd = '0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable & ~pwrite) prdata <= rd;
    end
  end
  // robbed-bit framing is decoded upstream; rx_sig_framing_ok carries it
endmodule

//--- testbench/tam_trunk_alarm_sva.sv
`timescale 1ns/100ps
module tam_trunk_alarm_chk
  import tam_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // line inputs seen by the card
  input wire logic carrier_present,
  input wire logic [23:0] chan_idle,
  // card outputs
  input wire tam_pkg::tam_state_e card_state,
  input wire tam_pkg::tam_tx_e tx_pattern,
  input wire tam_pkg::tam_led_s leds,
  input wire logic major_alarm,
  input wire logic accept_new_calls,
  input wire logic call_proc_en,
  input wire logic busy_trunks,
  input wire logic local_loop,
  input wire logic [23:0] chan_near_maint
);
  // three cycles of slack absorb the output register skew
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_active_quiet: assert property (
    (card_state == TAM_ACTIVE)[*3] |-> tx_pattern == TAM_TX_NONE
    && leds == '0) else $error("alarm pattern or led while active");
  a_maint_calls: assert property (
    (card_state == TAM_MAINT)[*3] |-> !accept_new_calls)
    else $error("new calls accepted in maintenance");
  a_near_maint: assert property (
    (card_state == TAM_MAINT && chan_idle == '1)[*6]
    |-> chan_near_maint == '1) else $error("idle channel not parked");
  a_oos_leds: assert property (
    (card_state == TAM_OOS)[*3] |-> leds.yellow && leds.green)
    else $error("out of service leds wrong");
  a_oos_pattern: assert property (
    (card_state == TAM_OOS)[*3]
    |-> tx_pattern inside {TAM_TX_ONES, TAM_TX_BLOCKED})
    else $error("out of service pattern wrong");
  a_oos_major: assert property (
    (card_state == TAM_OOS)[*3] |-> major_alarm)
    else $error("no major alarm out of service");
  a_diag_loop: assert property (
    (card_state == TAM_DIAG)[*3] |-> local_loop && !call_proc_en
    && tx_pattern inside {TAM_TX_ONES, TAM_TX_BLOCKED})
    else $error("diagnostic outputs wrong");
  a_carrier_major: assert property (
    (!carrier_present)[*8] |-> major_alarm && busy_trunks
    && card_state != TAM_ACTIVE) else $error("carrier loss not handled");
endmodule

bind tam_trunk_alarm tam_trunk_alarm_chk i_chk (.pclk, .presetn,
  .carrier_present, .chan_idle, .card_state, .tx_pattern, .leds,
  .major_alarm, .accept_new_calls, .call_proc_en, .busy_trunks,
  .local_loop, .chan_near_maint);

//--- testbench/tam_far_end.sv
`timescale 1ns/100ps
// fault 0 clean, 1 no carrier, 2 t1 yellow, 3 e1 rai, 4 multiframe
// loss, 5 pri yellow, 6 no sig framing, 7 no framing bit, 8 no align
module tam_far_end (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // condition chosen by the bench
  input wire logic [3:0] fault,
  input wire logic slip_req,
  // line indications toward the card
  output logic carrier_present,
  output logic rx_bit2_zero_all,
  output logic rx_rai,
  output logic rx_dma_bit,
  output logic rx_sig_framing_ok,
  output logic rx_term_framing_ok,
  output logic rx_frame_aligned,
  output logic rx_bit,
  output logic rx_bit_stb,
  output logic slip_evt,
  output logic dchan_alive
);
  logic [3:0] bit_cnt_reg;

  // static line conditions
  assign carrier_present = fault != 4'h1;
  assign rx_bit2_zero_all = fault == 4'h2;
  assign rx_rai = fault == 4'h3;
  assign rx_dma_bit = fault == 4'h4;
  assign rx_sig_framing_ok = fault != 4'h6;
  assign rx_term_framing_ok = fault != 4'h7;
  assign rx_frame_aligned = fault != 4'h8;
  assign dchan_alive = fault != 4'h9; // code 9 silences the d-channel

  // bit moves on the falling strobe so it is steady at the rising one;
  // a dead line shows no transitions at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bit_stb <= 1'b0;
      rx_bit <= 1'b0;
      bit_cnt_reg <= 4'h0;
      slip_evt <= 1'b0;
    end else begin
      slip_evt <= slip_req;
      if (fault != 4'h1) begin
        rx_bit_stb <= ~rx_bit_stb;
        if (rx_bit_stb) begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          // eight ones then eight zeros, else alternation
          rx_bit <= (fault == 4'h5) ? ~bit_cnt_reg[3] : bit_cnt_reg[0];
        end
      end
    end
  end
endmodule

//--- testbench/test_tam_trunk_alarm.sv
`timescale 1ns/100ps
module test_tam_trunk_alarm;
  import tam_pkg::*;
  localparam int OOF_N = 50;
  localparam int LOF_N = 30;
  // bench-driven inputs
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] fault = 4'h0;
  logic slip_req = 1'b0;
  logic [23:0] chan_idle = 24'h00_0000;
  // line signals and card outputs
  logic carrier_present, rx_bit2_zero_all, rx_rai, rx_dma_bit;
  logic rx_sig_framing_ok, rx_term_framing_ok, rx_frame_aligned;
  logic rx_bit, rx_bit_stb, slip_evt, dchan_alive, pready, pslverr;
  logic major_alarm, minor_alarm, accept_new_calls, call_proc_en;
  logic busy_trunks, local_loop, remote_loop;
  logic [31:0] prdata, q;
  logic [23:0] chan_near_maint;
  tam_state_e card_state;
  tam_tx_e tx_pattern;
  tam_led_s leds;
  int n_errors = 0;
  int n_compared = 0;

  // 250 MHz
  always #2 pclk = ~pclk;

  tam_far_end i_far (.pclk, .presetn, .fault, .slip_req,
    .carrier_present, .rx_bit2_zero_all, .rx_rai, .rx_dma_bit,
    .rx_sig_framing_ok, .rx_term_framing_ok, .rx_frame_aligned,
    .rx_bit, .rx_bit_stb, .slip_evt, .dchan_alive);

  // short counts keep the run small
  tam_trunk_alarm #(.T309_CYC(200), .OOF_CYC(OOF_N), .LOF_CYC(LOF_N),
    .WIN_CYC(40000)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .carrier_present,
    .rx_bit2_zero_all, .rx_rai, .rx_dma_bit, .rx_sig_framing_ok,
    .rx_term_framing_ok, .rx_frame_aligned, .rx_bit, .rx_bit_stb,
    .slip_evt, .dchan_alive, .chan_idle, .card_state, .tx_pattern,
    .leds, .major_alarm, .minor_alarm, .accept_new_calls,
    .call_proc_en, .busy_trunks, .local_loop, .remote_loop,
    .chan_near_maint);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // request held until pready is sampled high; read data lands in q
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    logic ok;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    q = prdata;
    ok = (pready === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge keeps back-to-back calls from reassigning psel
    @(posedge pclk);
    if (!ok) begin
      n_errors++;
      print_verdict();
    end
  endtask

  // control write, then time for the two-flop inputs and outputs
  task automatic ctl(input logic [31:0] d);
    apb(1'b1, TAM_CTRL_OFS, d);
    cyc(12);
  endtask

  task automatic t_reset;
    check(card_state, TAM_ACTIVE);
    check({tx_pattern, leds, major_alarm, minor_alarm}, 32'h0);
    apb(1'b0, TAM_SLIP_THR_OFS, 32'h0);
    check(q, 32'h0000_00FF);
    apb(1'b0, TAM_OOF_THR_OFS, 32'h0);
    check(q, 32'h0000_0004);
    apb(1'b0, TAM_LOF_THR_OFS, 32'h0);
    check(q, 32'h0000_0004);
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    apb(1'b0, 8'h40, 32'h0);
    check(card_state, TAM_ACTIVE);
  endtask

  task automatic t_remote;
    logic [3:0] codes [4] = '{4'h2, 4'h3, 4'h4, 4'h5};
    logic [1:0] vars [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    for (int k = 0; k < 4; k++) begin
      ctl({30'h0, vars[k]});
      fault <= codes[k];
      cyc(80);
      check(card_state, TAM_MAINT);
      check(leds.yellow & minor_alarm, 1'b1);
      fault <= 4'h0;
      cyc(48);
      check(card_state, TAM_ACTIVE);
    end
  endtask

  task automatic t_line_loss;
    ctl(32'h0);
    fault <= 4'h1;
    cyc(12);
    check(card_state, TAM_MAINT);
    check(tx_pattern, TAM_TX_YELLOW);
    check(leds.red & busy_trunks & major_alarm, 1'b1);
    fault <= 4'h6;
    cyc(24);
    check(leds.red & minor_alarm, 1'b1);
    fault <= 4'h0;
    cyc(24);
    check(card_state, TAM_ACTIVE);
  endtask

  task automatic t_oof;
    apb(1'b1, TAM_OOF_THR_OFS, 32'h2);
    for (int k = 0; k < 2; k++) begin
      fault <= 4'h7;
      cyc(OOF_N + 12);
      check(card_state, TAM_MAINT);
      check(leds.red & minor_alarm, 1'b1);
      check(tx_pattern, TAM_TX_YELLOW);
      fault <= 4'h0;
      cyc(12);
      check(card_state, TAM_ACTIVE);
      apb(1'b0, TAM_STAT_OFS, 32'h0);
      check(q[10], k[0]);
    end
    ctl(32'h80);
    apb(1'b0, TAM_STAT_OFS, 32'h0);
    check(q[10], 1'b0);
  endtask

  task automatic t_lof;
    apb(1'b1, TAM_LOF_THR_OFS, 32'h1);
    ctl(32'h5);
    fault <= 4'h8;
    cyc(LOF_N + 12);
    check(card_state, TAM_MAINT);
    check(tx_pattern, TAM_TX_RAI);
    fault <= 4'h0;
    cyc(12);
    check(card_state, TAM_MAINT);
    ctl(32'h45);
    check(card_state, TAM_ACTIVE);
    apb(1'b0, TAM_STAT_OFS, 32'h0);
    check(q[11], 1'b1);
  endtask

  task automatic t_slip;
    apb(1'b1, TAM_SLIP_THR_OFS, 32'h3);
    ctl(32'h84);
    for (int k = 0; k < 3; k++) begin
      check(card_state, TAM_ACTIVE);
      slip_req <= 1'b1;
      cyc(3);
      slip_req <= 1'b0;
      cyc(12);
    end
    check(card_state, TAM_MAINT);
    check(minor_alarm, 1'b1);
    ctl(32'h44);
    check(card_state, TAM_MAINT);
    ctl(32'h14);
    check(tx_pattern, TAM_TX_ONES);
    check(leds.yellow & leds.green & major_alarm, 1'b1);
    ctl(32'h44);
    check(card_state, TAM_ACTIVE);
  endtask

  task automatic t_modes;
    ctl(32'h11);
    check(tx_pattern, TAM_TX_BLOCKED);
    ctl(32'h41);
    ctl(32'h121);
    check(card_state, TAM_DIAG);
    check({local_loop, remote_loop, call_proc_en}, 3'h6);
    ctl(32'h41);
    ctl(32'h8);
    check(card_state, TAM_MAINT);
    chan_idle <= 24'h00_F00F;
    cyc(12);
    check(chan_near_maint, 24'h00_F00F);
    chan_idle <= 24'hFF_FFFF;
    cyc(12);
    ctl(32'h40);
    ctl(32'h200);
    check(card_state, TAM_MAINT);
    ctl(32'h0);
    check(card_state, TAM_ACTIVE);
    ctl(32'h400);
    check(major_alarm, 1'b1);
    ctl(32'h2);
    fault <= 4'h9;
    cyc(100);
    check(major_alarm, 1'b0);
    cyc(120);
    check(major_alarm, 1'b1);
    fault <= 4'h0;
  endtask

  task automatic t_window;
    apb(1'b0, TAM_CNT_OFS, 32'h0);
    check(q, 32'h0001_0203);
    cyc(40000);
    apb(1'b0, TAM_CNT_OFS, 32'h0);
    check(q, 32'h0000_0000);
  endtask

  initial begin
    cyc(10);
    presetn <= 1'b1;
    cyc(4);
    t_reset();
    t_remote();
    t_line_loss();
    t_oof();
    t_lof();
    t_slip();
    t_modes();
    t_window();
    print_verdict();
  end
endmodule
